//--- pkg/otlp_pkg.sv
/*
 Constants for the output tristate and power-save controller.
 Assumes a register write/read port driven by the serial-bus front end.
*/
`default_nettype none
package otlp_pkg;
	localparam logic [7:0] ADDR_OUT_CTRL   = 8'hF2;
	localparam logic [7:0] ADDR_POWER_SAVE = 8'hAA;
	localparam int         BIT_OE_DISABLE  = 7;
	localparam int         BIT_TRI_VIDEO   = 0;
	localparam int         BIT_TRI_SYNC    = 1;
	localparam int         BIT_TRI_PIXEL_CLOCK_OUT  = 2;
	localparam logic [7:0] OUT_CTRL_RESET  = 8'h00;
	localparam logic [1:0] LEVEL_ACTIVE    = 2'h0;
	localparam logic [1:0] LEVEL_SLEEP     = 2'h3;
	localparam logic [5:0] PS_RSVD_ZERO    = 6'h00;
	localparam int         DIV_W           = 3;
	localparam int         SYNC_W          = 5;
	typedef enum logic [1:0] {OTLP_RUN, OTLP_WAIT_EOL, OTLP_WAIT_LINE, OTLP_SAVE} otlp_ps_e;
endpackage
`default_nettype wire

//--- hdl/otlp_output_tristate_lowpower_ctrl.sv
/*
 Output driver enable priority chain and power-save sequencing.
 Assumes a TAP block supplying its mode flags and enable cells, a serial-bus
 front end giving one-cycle write strobes, and a line-start pulse from sync.
*/
// Operation
// - Boundary scan overrides all other enables
// - EXTEST/CLAMP: enables follow scan enable cells
// - HIGHZ: every output tristated
// - Reset low outside EXTEST/CLAMP/HIGHZ tristates all outputs except scan data
// - Scan data output ignores chip reset
// - Output-control register tristates signal groups
// - Drive pin affects only video data ports
// - Control bit 7 disables drive pin
// - Pin low: data and sync outputs drive
// - Pin high: data tristated, sync drives
// - Pixel clock pin high at release: power-save
// - Power-save register write enters/leaves mode
// - Finish one whole line before tristating
// - Registers keep contents during power-save
// - Registers accessible during power-save
// - Levels one and two allow 400 kbit/s
// - Level codes: active, divide by 2,4,8
`timescale 1ns/10ps
`default_nettype none
module otlp_output_tristate_lowpower_ctrl (
	input  wire logic       mclk_in,              // System clock, 100 MHz
	input  wire logic       rst_n_in,             // Async reset, active low
	input  wire logic       chip_reset_n_in,      // Chip reset pin, active low
	input  wire logic       pixel_clock_out_in,   // Pixel clock pin level, strap
	input  wire logic       video_port_drive_n_in,// Video port enable pin, active low
	input  wire logic       tap_extest_in,        // TAP in EXTEST
	input  wire logic       tap_clamp_in,         // TAP in CLAMP
	input  wire logic       tap_highz_in,         // TAP in HIGHZ
	input  wire logic [3:0] scan_enable_in,       // Scan enable cells: data,sync,pix,tdo
	input  wire logic       tap_tdo_active_in,    // TAP shifting, scan data valid
	input  wire logic       line_start_in,        // One-cycle pulse at each line start
	input  wire logic       reg_write_in,         // Register write strobe
	input  wire logic       reg_read_in,          // Register read strobe
	input  wire logic [7:0] reg_addr_in,          // Register address
	input  wire logic [7:0] reg_wdata_in,         // Register write data
	output logic      [7:0] reg_rdata_out,        // Register read data
	output logic            data_drive_out,       // Drive port_a/port_b data
	output logic            sync_drive_out,       // Drive reference/flag/llc outputs
	output logic            pixel_clock_out_drive_out,     // Drive pixel clock output
	output logic            tdo_drive_out,        // Drive scan data output
	output logic            clk_div_en_out,       // Internal clock enable pulse
	output logic      [1:0] power_save_level_out, // Active power-save level
	output logic            power_save_out        // Outputs parked by power-save
);
	localparam int SYNC_W = 2;
	localparam int DIV_W  = otlp_pkg::DIV_W;

	// Whole module state: one record, one register
	typedef struct packed {
		logic [SYNC_W-1:0]     sync_rst;
		logic [SYNC_W-1:0]     sync_strap;
		logic [SYNC_W-1:0]     sync_pin;
		logic                  rst_seen;
		logic [7:0]            out_ctrl;
		logic [1:0]            level;
		otlp_pkg::otlp_ps_e    ps;
		logic [DIV_W-1:0]      div;
		logic [7:0]            rdata;
		logic                  data_drv;
		logic                  sync_drv;
		logic                  pix_drv;
		logic                  tdo_drv;
		logic                  clk_en;
		logic [1:0]            lvl_out;
		logic                  ps_out;
	} otlp_state_s;

	otlp_state_s cur;
	otlp_state_s next_cur;

	logic             rst_sync;
	logic             strap_sync;
	logic             pin_sync;
	logic             scan_cells;
	logic             scan_mode;
	logic             parked;
	logic             rst_edge;
	logic             tri_video;
	logic             tri_sync;
	logic             tri_pix;
	logic             pin_ignored;
	logic             wr_out_ctrl;
	logic             wr_power_save;
	logic             rd_out_ctrl;
	logic             rd_power_save;
	logic [DIV_W-1:0] div_mask;

	// Decode shared by the state update below
	always_comb
	begin
		// Synchronised pin levels: last flop of each chain
		rst_sync      = cur.sync_rst[SYNC_W-1];
		strap_sync    = cur.sync_strap[SYNC_W-1];
		pin_sync      = cur.sync_pin[SYNC_W-1];
		scan_cells    = tap_extest_in || tap_clamp_in;
		scan_mode     = scan_cells || tap_highz_in;
		parked        = (cur.ps == otlp_pkg::OTLP_SAVE);
		rst_edge      = rst_sync && !cur.rst_seen;

		// Register field decode
		tri_video     = cur.out_ctrl[otlp_pkg::BIT_TRI_VIDEO];
		tri_sync      = cur.out_ctrl[otlp_pkg::BIT_TRI_SYNC];
		tri_pix       = cur.out_ctrl[otlp_pkg::BIT_TRI_PIXEL_CLOCK_OUT];
		pin_ignored   = cur.out_ctrl[otlp_pkg::BIT_OE_DISABLE];

		wr_out_ctrl   = reg_write_in && (reg_addr_in == otlp_pkg::ADDR_OUT_CTRL);
		wr_power_save = reg_write_in && (reg_addr_in == otlp_pkg::ADDR_POWER_SAVE);
		rd_out_ctrl   = reg_read_in && (reg_addr_in == otlp_pkg::ADDR_OUT_CTRL);
		rd_power_save = reg_read_in && (reg_addr_in == otlp_pkg::ADDR_POWER_SAVE);
	end

	// Divider wrap point: 2, 4 or 8 system clocks per enable
	always_comb
	begin
		unique case (cur.level)
			2'h0:
			begin
				div_mask = 3'h0;
			end
			2'h1:
			begin
				div_mask = 3'h1;
			end
			2'h2:
			begin
				div_mask = 3'h3;
			end
			2'h3:
			begin
				div_mask = 3'h7;
			end
		endcase
	end

	always_comb
	begin
		next_cur = cur;
		// Pins cross in through two flops; only the second stage is read
		next_cur.sync_rst   = {cur.sync_rst[0], chip_reset_n_in};
		next_cur.sync_strap = {cur.sync_strap[0], pixel_clock_out_in};
		next_cur.sync_pin   = {cur.sync_pin[0], video_port_drive_n_in};

		// Strap caught on the clocked rising edge of chip reset
		next_cur.rst_seen = rst_sync;
		if (!rst_sync)
		begin
			next_cur.out_ctrl = otlp_pkg::OUT_CTRL_RESET;
			next_cur.level    = otlp_pkg::LEVEL_ACTIVE;
			next_cur.ps       = otlp_pkg::OTLP_RUN;
		end
		else if (rst_edge && strap_sync)
		begin
			// Strap pulled high: come up parked at the deepest level
			next_cur.level = otlp_pkg::LEVEL_SLEEP;
			next_cur.ps    = otlp_pkg::OTLP_SAVE;
		end
		else
		begin
			// Writes accepted at every level; parking never clears them
			if (wr_out_ctrl)
			begin
				next_cur.out_ctrl = reg_wdata_in;
			end

			if (wr_power_save)
			begin
				// Reserved bits are dropped; only the level is kept
				next_cur.level = reg_wdata_in[1:0];
				if (reg_wdata_in[1:0] == otlp_pkg::LEVEL_ACTIVE)
				begin
					next_cur.ps = otlp_pkg::OTLP_RUN;
				end
				else if (cur.ps == otlp_pkg::OTLP_RUN)
				begin
					next_cur.ps = otlp_pkg::OTLP_WAIT_EOL;
				end
			end
			else
			begin
				// Run to the next line start, then one whole line more
				unique case (cur.ps)
					otlp_pkg::OTLP_RUN:
					begin
						next_cur.ps = otlp_pkg::OTLP_RUN;
					end
					otlp_pkg::OTLP_WAIT_EOL:
					begin
						if (line_start_in)
						begin
							next_cur.ps = otlp_pkg::OTLP_WAIT_LINE;
						end
					end
					otlp_pkg::OTLP_WAIT_LINE:
					begin
						if (line_start_in)
						begin
							next_cur.ps = otlp_pkg::OTLP_SAVE;
						end
					end
					otlp_pkg::OTLP_SAVE:
					begin
						next_cur.ps = otlp_pkg::OTLP_SAVE;
					end
				endcase
			end
		end

		// Full rate until parked, so the final line completes at speed
		if (!parked || cur.div == div_mask)
		begin
			next_cur.div    = '0;
			next_cur.clk_en = 1'b1;
		end
		else
		begin
			next_cur.div    = cur.div + 3'h1;
			next_cur.clk_en = 1'b0;
		end

		// Reads answer at every level; reserved bits read as zero
		if (rd_power_save)
		begin
			next_cur.rdata = {otlp_pkg::PS_RSVD_ZERO, cur.level};
		end
		else if (rd_out_ctrl)
		begin
			next_cur.rdata = cur.out_ctrl;
		end
		else if (reg_read_in)
		begin
			// Unmapped reads return zero
			next_cur.rdata = 8'h00;
		end

		// Priority chain: scan, reset, power-save, register, pin
		if (scan_mode)
		begin
			if (tap_highz_in)
			begin
				next_cur.data_drv = 1'b0;
				next_cur.sync_drv = 1'b0;
				next_cur.pix_drv  = 1'b0;
				next_cur.tdo_drv  = 1'b0;
			end
			else
			begin
				next_cur.data_drv = scan_enable_in[0];
				next_cur.sync_drv = scan_enable_in[1];
				next_cur.pix_drv  = scan_enable_in[2];
				next_cur.tdo_drv  = scan_enable_in[3];
			end
		end
		else if (!rst_sync)
		begin
			// Chip reset parks every group except scan data
			next_cur.data_drv = 1'b0;
			next_cur.sync_drv = 1'b0;
			next_cur.pix_drv  = 1'b0;
			next_cur.tdo_drv  = tap_tdo_active_in;
		end
		else if (parked)
		begin
			// Scan data output keeps working while parked
			next_cur.data_drv = 1'b0;
			next_cur.sync_drv = 1'b0;
			next_cur.pix_drv  = 1'b0;
			next_cur.tdo_drv  = tap_tdo_active_in;
		end
		else
		begin
			next_cur.tdo_drv  = tap_tdo_active_in;
			next_cur.pix_drv  = !tri_pix;
			next_cur.sync_drv = !tri_sync;
			// Data group: register first, then the pin
			// Limitation: the pin acts three clocks late, via its synchroniser
			if (tri_video)
			begin
				next_cur.data_drv = 1'b0;
			end
			else if (pin_ignored)
			begin
				next_cur.data_drv = 1'b1;
			end
			else
			begin
				next_cur.data_drv = !pin_sync;
			end
		end

		// Level and park flags follow the state one clock later
		next_cur.lvl_out = cur.level;
		next_cur.ps_out  = parked;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		// Asynchronous reset loads constants only
		if (!rst_n_in)
		begin
			cur.sync_rst   <= '0;
			cur.sync_strap <= '0;
			cur.sync_pin   <= '0;
			cur.rst_seen   <= 1'b0;
			cur.out_ctrl   <= otlp_pkg::OUT_CTRL_RESET;
			cur.level      <= otlp_pkg::LEVEL_ACTIVE;
			cur.ps         <= otlp_pkg::OTLP_RUN;
			cur.div        <= '0;
			cur.rdata      <= 8'h00;
			cur.data_drv   <= 1'b0;
			cur.sync_drv   <= 1'b0;
			cur.pix_drv    <= 1'b0;
			cur.tdo_drv    <= 1'b0;
			cur.clk_en     <= 1'b0;
			cur.lvl_out    <= otlp_pkg::LEVEL_ACTIVE;
			cur.ps_out     <= 1'b0;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	// Outputs taken straight from the registered record
	always_comb
	begin
		reg_rdata_out        = cur.rdata;
		data_drive_out       = cur.data_drv;
		sync_drive_out       = cur.sync_drv;
		pixel_clock_out_drive_out     = cur.pix_drv;
		tdo_drive_out        = cur.tdo_drv;
		clk_div_en_out       = cur.clk_en;
		power_save_level_out = cur.lvl_out;
		power_save_out       = cur.ps_out;
	end
endmodule
`default_nettype wire

//--- sim/otlp_asserts.sv
/* Port checker for the output tristate and power-save controller.
 Bound to the design top; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module otlp_asserts (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic chip_reset_n_in,
	input wire logic tap_extest_in,
	input wire logic tap_clamp_in,
	input wire logic tap_highz_in,
	input wire logic [3:0] scan_enable_in,
	input wire logic line_start_in,
	input wire logic reg_write_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic data_drive_out,
	input wire logic sync_drive_out,
	input wire logic pixel_clock_out_drive_out,
	input wire logic tdo_drive_out,
	input wire logic clk_div_en_out,
	input wire logic [1:0] power_save_level_out,
	input wire logic power_save_out
);
	wire [3:0] drv = {tdo_drive_out, pixel_clock_out_drive_out, sync_drive_out, data_drive_out};
	wire tap = tap_extest_in | tap_clamp_in | tap_highz_in;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_exit;
		reg_write_in && reg_addr_in == otlp_pkg::ADDR_POWER_SAVE && reg_wdata_in[1:0] == 2'h0;
	endsequence
	a_highz_all_off: assert property (tap_highz_in |=> drv == 4'h0)
		else $error("drive in highz");
	a_scan_follows: assert property ((tap_extest_in || tap_clamp_in) && !tap_highz_in
		|=> drv == $past(scan_enable_in)) else $error("scan cells ignored");
	a_reset_tristate: assert property ((!chip_reset_n_in && !tap)[*4] |=> drv[2:0] == 3'h0)
		else $error("drive in chip reset");
	a_park_off: assert property (power_save_out && !tap && !$past(tap) |-> drv[2:0] == 3'h0)
		else $error("drive while parked");
	a_park_level: assert property ($rose(power_save_out) |-> power_save_level_out != 2'h0)
		else $error("parked at level 0");
	a_line_first: assert property ($rose(power_save_out) && $past(power_save_level_out) != 2'h0
		|-> $past(line_start_in) || $past(line_start_in, 2)) else $error("parked mid line");
	a_exit_resume: assert property (s_exit ##0 power_save_out |-> ##[1:2] !power_save_out)
		else $error("no exit");
	a_div_by_four: assert property ($rose(clk_div_en_out) && $past(power_save_out, 4)
		&& power_save_level_out == 2'h2 |-> $past(clk_div_en_out, 4) && !$past(clk_div_en_out, 2))
		else $error("divide by four broken");
endmodule
bind otlp_output_tristate_lowpower_ctrl otlp_asserts u_chk (.*);
`default_nettype wire

//--- sim/otlp_line_source.sv
/* Line start source standing in for the sync stage.
 Runs on the system clock from reset. */
`timescale 1ns/10ps
`default_nettype none
module otlp_line_source #(parameter int LINE_CYC = 20) (
	input  wire logic mclk_in,       // System clock
	input  wire logic rst_n_in,      // Reset, active low
	output logic      line_start_out // One pulse per line
);
	logic [7:0] cnt;
	always_ff @(posedge mclk_in or negedge rst_n_in)
		if (!rst_n_in)
			cnt <= 8'h01;
		else
			cnt <= (cnt == 8'(LINE_CYC - 1)) ? 8'h00 : cnt + 8'h01;
	assign line_start_out = (cnt == 8'h00);
endmodule
`default_nettype wire

//--- sim/tb_output_tristate_lowpower_ctrl.sv
/* Bench for the output tristate and power-save controller.
 Line pulses come from the line source model; all else is driven here. */
`timescale 1ns/10ps
`default_nettype none
module tb_output_tristate_lowpower_ctrl;
	logic mclk_in = 1'b0, rst_n_in = 1'b0, chip_reset_n_in = 1'b0, tap_tdo_active_in = 1'b0;
	logic pixel_clock_out_in = 1'b0, video_port_drive_n_in = 1'b0, reg_read_in = 1'b0;
	logic tap_extest_in = 1'b0, tap_clamp_in = 1'b0, tap_highz_in = 1'b0, reg_write_in = 1'b0;
	logic [3:0] scan_enable_in = 4'h0;
	logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
	logic [1:0] power_save_level_out;
	logic line_start_in, data_drive_out, sync_drive_out, pixel_clock_out_drive_out, tdo_drive_out;
	logic clk_div_en_out, power_save_out;
	int err_count = 0, cmp_count = 0;
	wire [3:0] drv = {tdo_drive_out, pixel_clock_out_drive_out, sync_drive_out, data_drive_out};
	always #5 mclk_in = ~mclk_in;
	otlp_line_source u_line (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.line_start_out(line_start_in));
	otlp_output_tristate_lowpower_ctrl u_dut (.*);
	task automatic chk(input logic [7:0] s, e);
		cmp_count++;
		if (s !== e)
		begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic ck(input int n);
		repeat (n) @(posedge mclk_in);
	endtask
	task automatic dc(input logic [3:0] e);
		#1 chk(drv, e);
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge mclk_in);
		reg_write_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge mclk_in);
		reg_write_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge mclk_in);
		reg_read_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge mclk_in);
		reg_read_in <= 1'b0;
		#1 chk(reg_rdata_out, e);
	endtask
	task automatic wps(input logic v);
		int i;
		i = 0;
		while (power_save_out !== v && i < 100)
			@(posedge mclk_in) #1 i++;
		chk(power_save_out, v);
	endtask
	task automatic dv(input int l);
		int p;
		p = 0;
		repeat (8)
		begin
			@(posedge mclk_in) #1;
			p += int'(clk_div_en_out);
		end
		chk(8'(p), 8'(8 >> l));
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		ck(5);
		rst_n_in <= 1'b1;
		ck(2);
		chip_reset_n_in <= 1'b1;
		ck(5);
		rd(otlp_pkg::ADDR_POWER_SAVE, 8'h00);
		rd(otlp_pkg::ADDR_OUT_CTRL, otlp_pkg::OUT_CTRL_RESET);
		rd(8'h10, 8'h00);
		dc(4'h7);
		@(posedge mclk_in) video_port_drive_n_in <= 1'b1;
		ck(5);
		dc(4'h6);
		wr(otlp_pkg::ADDR_OUT_CTRL, 8'h80);
		ck(2);
		dc(4'h7);
		wr(otlp_pkg::ADDR_OUT_CTRL, 8'h83);
		ck(2);
		dc(4'h4);
		$display("test pins done");
		for (int m = 0; m < 3; m++)
		begin
			@(posedge mclk_in);
			{tap_highz_in, tap_clamp_in, tap_extest_in} <= 3'(1 << m);
			scan_enable_in <= 4'hA;
			chip_reset_n_in <= m[0];
			ck(5);
			dc(m == 2 ? 4'h0 : 4'hA);
		end
		@(posedge mclk_in);
		{tap_highz_in, tap_clamp_in, tap_extest_in} <= 3'h0;
		tap_tdo_active_in <= 1'b1;
		ck(5);
		dc(4'h8);
		@(posedge mclk_in);
		chip_reset_n_in <= 1'b1;
		tap_tdo_active_in <= 1'b0;
		ck(4);
		wr(otlp_pkg::ADDR_OUT_CTRL, 8'h80);
		ck(2);
		dc(4'h7);
		$display("test scan done");
		for (int l = 1; l < 4; l++)
		begin
			wr(otlp_pkg::ADDR_POWER_SAVE, 8'(l));
			ck(3);
			dc(4'h7);
			chk(power_save_out, 1'b0);
			wps(1'b1);
			dc(4'h0);
			dv(l);
			rd(otlp_pkg::ADDR_POWER_SAVE, 8'(l));
			if (l == 3)
				chk(power_save_level_out, 2'h3);
			rd(otlp_pkg::ADDR_OUT_CTRL, 8'h80);
			wr(otlp_pkg::ADDR_POWER_SAVE, 8'h00);
			ck(3);
			dc(4'h7);
		end
		$display("test power save done");
		@(posedge mclk_in);
		chip_reset_n_in <= 1'b0;
		pixel_clock_out_in <= 1'b1;
		ck(5);
		chip_reset_n_in <= 1'b1;
		wps(1'b1);
		chk(power_save_level_out, 2'h3);
		$display("test strap done");
		conclude();
	end
	initial
	begin
		#100000;
		err_count++;
		conclude();
	end
endmodule
`default_nettype wire
